/* File: core/nfps_top.sv */
// How it works
// - command, address and data bytes share one 8-bit two-way bus
// - low ready/busy of the selected flash holds off the next operation
// - write strobe pulses low; flash latches the byte on its rising edge
// - one of two read strobes pulses low; flash presents next byte
// - command latch strobe high while the bus carries a command
// - address latch strobe high while the bus carries an address
// - data activity indicator driven low during host transfers after initialisation, else high impedance
// - chip active indicator driven low only once initialised
// - switch low: report protection, drive flash protect, refuse config writes
// - flash protect waits until pending transfers and operations finish
// - eight active-low chip selects pick the addressed flash
// - reset pin held low 10 ms restarts the startup sequence
// - link runs at full or high speed, never low speed
// - valid stored configuration loads descriptors and selects normal mode
// - missing flash or bad configuration selects defaults and manufacturing mode
// - ordinary host flash access only in normal mode
// - manufacturing mode still allows configuration area programming and tests
// - keeps vendor, product and write protection capability items
// - all timing derives from one reference clock
`include "nfps_consts.svh"

module nfps_top import nfps_pkg::*; #(
	parameter int RST_HOLD_CYC = `NFPS_RST_HOLD_CYC
) (
	input  wire logic           clk_sys,
	input  wire logic           rst,
	input  wire logic           reset_in_n,
	input  wire nfps_req_type   req,
	input  wire logic           req_valid,
	output logic                req_ready,
	output logic                req_refused,
	output logic          [7:0] rd_data,
	output logic                rd_valid,
	input  wire logic           rd_ready,
	output nfps_pins_type       flash_pins,
	input  wire logic     [7:0] flash_dq_in,
	input  wire logic     [1:0] flash_ready_busy_n,
	input  wire logic           write_protect_switch_n,
	output logic                flash_write_protect_out_n,
	output logic                flash_write_protect_oe_n,
	output logic                data_activity_indicator_n,
	output logic                data_activity_oe_n,
	output logic                chip_active_indicator_n,
	output logic                chip_active_oe_n,
	input  wire nfps_speed_type speed_req,
	output nfps_speed_type      speed_grant,
	output logic                normal_mode,
	output logic                init_done,
	output logic                media_write_protected,
	output nfps_cfg_type        cfg
);
	typedef enum {ENG_IDLE, ENG_SETUP, ENG_STROBE, ENG_HOLD} nfps_eng_type;

	function automatic logic [7:0] nfps_chip_onehot(input logic [2:0] chip);
		return 8'(8'h01 << chip);
	endfunction

	function automatic logic [3:0] nfps_strobe_len(input nfps_op_type op);
		// read stays low long enough for the pin data to cross the synchroniser
		if (op == NFPS_OP_READ) begin
			return 4'(`NFPS_STROBE_CYC + `NFPS_SYNC_LAT + 1);
		end
		return 4'(`NFPS_STROBE_CYC);
	endfunction

	function automatic nfps_req_type nfps_boot_req(input logic [3:0] step);
		nfps_req_type r;
		r.op       = NFPS_OP_READ;
		r.chip     = 3'h0;
		r.cfg_area = 1'b1;
		r.data     = `NFPS_CFG_ADDR;
		if (step == 4'h0) begin
			r.op   = NFPS_OP_CMD;
			r.data = `NFPS_CMD_READ;
		end else if (step < 4'h3) begin
			r.op = NFPS_OP_ADDR;
		end else if (step == 4'h3) begin
			r.op   = NFPS_OP_CMD;
			r.data = `NFPS_CMD_CONFIRM;
		end
		return r;
	endfunction

	logic         [7:0]  dq_s;
	logic         [1:0]  rb_s;
	logic                write_protect_switch_n_s;
	logic                reset_in_s;
	logic         [19:0] rst_cnt_r;
	logic                pin_rst_r;
	nfps_eng_type        state_r;
	nfps_req_type        op_r;
	logic         [3:0]  cnt_r;
	logic         [3:0]  gap_r;
	logic         [3:0]  boot_step_r;
	logic         [47:0] boot_bytes_r;
	logic                sel_r;
	logic                init_done_r;
	logic                normal_r;
	nfps_cfg_type        cfg_r;
	logic                refused_r;
	logic                xfer_busy_r;
	logic                flash_write_protect_out_n_r;
	nfps_speed_type      speed_r;
	nfps_pins_type       pins_r;
	nfps_pins_type       pins_nxt;
	logic                fifo_in_ready;

	nfps_sync #(.W(12)) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({reset_in_n, write_protect_switch_n, flash_ready_busy_n, flash_dq_in}),
		.dout    ({reset_in_s, write_protect_switch_n_s, rb_s, dq_s})
	);

	wire          core_rst   = rst | pin_rst_r;
	wire nfps_req_type cur_req = init_done_r ? req : nfps_boot_req(boot_step_r);
	wire          cur_read   = cur_req.op == NFPS_OP_READ;
	wire          eng_free   = (state_r == ENG_IDLE) & (gap_r == 4'h0);
	wire          rb_ok      = rb_s[cur_req.chip[2]];
	wire          wp_active  = ~write_protect_switch_n_s & cfg_r.wp_capable;
	wire          mode_ok    = normal_r | req.cfg_area;
	wire          cfg_wr_blk = wp_active & req.cfg_area & (req.op == NFPS_OP_WRITE);
	wire          refuse     = ~mode_ok | cfg_wr_blk;
	wire          fifo_ok    = ~cur_read | fifo_in_ready | ~init_done_r;
	wire          can_run    = eng_free & rb_ok & fifo_ok;
	wire          boot_go    = ~init_done_r & (boot_step_r != `NFPS_BOOT_STEPS) & can_run;
	wire          host_go    = req_valid & req_ready & ~refuse;
	wire          start      = boot_go | host_go;
	wire          op_active  = state_r != ENG_IDLE;
	wire          op_is_rd   = op_r.op == NFPS_OP_READ;
	wire          capture    = (state_r == ENG_STROBE) & (cnt_r == 4'h1) & op_is_rd;
	wire          boot_done  = ~init_done_r & (boot_step_r == `NFPS_BOOT_STEPS) & eng_free;
	wire          sig_ok     = boot_bytes_r[47:40] == `NFPS_CFG_SIG;
	wire          xfer_busy  = op_active | req_valid | rd_valid | (gap_r != 4'h0);

	assign req_ready = init_done_r & (refuse | can_run);

	// pins are decoded from state and registered so the strobes never glitch
	always_comb begin
		pins_nxt.ce_n    = sel_r ? ~nfps_chip_onehot(op_r.chip) : 8'hFF;
		pins_nxt.cle     = op_active & (op_r.op == NFPS_OP_CMD);
		pins_nxt.ale     = op_active & (op_r.op == NFPS_OP_ADDR);
		pins_nxt.we_n    = ~((state_r == ENG_STROBE) & ~op_is_rd);
		pins_nxt.flash_read_strobe_n = 2'h3;
		if ((state_r == ENG_STROBE) & op_is_rd) begin
			pins_nxt.flash_read_strobe_n = op_r.chip[2] ? 2'h1 : 2'h2;
		end
		pins_nxt.dq_out  = op_r.data;
		pins_nxt.dq_oe_n = ~(op_active & ~op_is_rd);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rst_cnt_r <= 20'h0;
			pin_rst_r <= 1'b0;
		end else if (reset_in_s) begin
			rst_cnt_r <= 20'h0;
			pin_rst_r <= 1'b0;
		end else if (rst_cnt_r == 20'(RST_HOLD_CYC)) begin
			pin_rst_r <= 1'b1;
		end else begin
			rst_cnt_r <= rst_cnt_r + 20'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (core_rst) begin
			state_r <= ENG_IDLE;
			op_r    <= '0;
			cnt_r   <= 4'h0;
			gap_r   <= 4'h0;
			sel_r   <= 1'b0;
		end else begin
			unique case (state_r)
				ENG_IDLE: begin
					if (gap_r != 4'h0) begin
						gap_r <= gap_r - 4'h1;
					end
					if (start) begin
						state_r <= ENG_SETUP;
						op_r    <= cur_req;
						cnt_r   <= 4'(`NFPS_SETUP_CYC);
						sel_r   <= 1'b1;
					end
				end
				ENG_SETUP: begin
					cnt_r <= cnt_r - 4'h1;
					if (cnt_r == 4'h1) begin
						state_r <= ENG_STROBE;
						cnt_r   <= nfps_strobe_len(op_r.op);
					end
				end
				ENG_STROBE: begin
					cnt_r <= cnt_r - 4'h1;
					if (cnt_r == 4'h1) begin
						state_r <= ENG_HOLD;
					end
				end
				ENG_HOLD: begin
					state_r <= ENG_IDLE;
					// busy only shows on the synchronised line after a command
					gap_r   <= (op_r.op == NFPS_OP_CMD) ? 4'(`NFPS_WB_CYC) : 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (core_rst) begin
			boot_step_r  <= 4'h0;
			boot_bytes_r <= 48'h0;
			init_done_r  <= 1'b0;
			normal_r     <= 1'b0;
			cfg_r        <= '0;
		end else begin
			if (boot_go) begin
				boot_step_r <= boot_step_r + 4'h1;
			end
			if (capture & ~init_done_r) begin
				boot_bytes_r <= {boot_bytes_r[39:0], dq_s};
			end
			if (boot_done) begin
				init_done_r <= 1'b1;
				normal_r    <= sig_ok;
				if (sig_ok) begin
					cfg_r.vendor     <= boot_bytes_r[39:24];
					cfg_r.product    <= boot_bytes_r[23:8];
					cfg_r.wp_capable <= boot_bytes_r[`NFPS_FLAG_WP_BIT];
				end else begin
					cfg_r.vendor     <= `NFPS_DEF_VENDOR;
					cfg_r.product    <= `NFPS_DEF_PRODUCT;
					cfg_r.wp_capable <= `NFPS_DEF_WP_CAP;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (core_rst) begin
			pins_r      <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, flash_read_strobe_n: 2'h3,
				ce_n: 8'hFF, dq_out: 8'h00, dq_oe_n: 1'b1};
			refused_r   <= 1'b0;
			xfer_busy_r <= 1'b0;
			flash_write_protect_out_n_r     <= 1'b0;
			speed_r     <= NFPS_SPD_FULL;
		end else begin
			pins_r      <= pins_nxt;
			refused_r   <= req_valid & req_ready & refuse;
			xfer_busy_r <= init_done_r & xfer_busy;
			if (~wp_active) begin
				flash_write_protect_out_n_r <= 1'b0;
			end else if (~xfer_busy) begin
				flash_write_protect_out_n_r <= 1'b1;
			end
			// low speed requests fall back to full speed
			speed_r     <= (speed_req == NFPS_SPD_HIGH) ? NFPS_SPD_HIGH : NFPS_SPD_FULL;
		end
	end

	nfps_fifo #(.W(`NFPS_DATA_W), .D(`NFPS_FIFO_DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (core_rst),
		.in_valid  (capture & init_done_r),
		.in_ready  (fifo_in_ready),
		.in_data   (dq_s),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	assign flash_pins                = pins_r;
	assign req_refused               = refused_r;
	assign flash_write_protect_out_n = ~flash_write_protect_out_n_r;
	assign flash_write_protect_oe_n  = ~init_done_r;
	assign data_activity_indicator_n = 1'b0;
	assign data_activity_oe_n        = ~xfer_busy_r;
	assign chip_active_indicator_n   = 1'b0;
	assign chip_active_oe_n          = ~init_done_r;
	assign speed_grant               = speed_r;
	assign normal_mode               = normal_r;
	assign init_done                 = init_done_r;
	assign media_write_protected     = wp_active;
	assign cfg                       = cfg_r;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (core_rst);

	sequence seq_we_pulse;
		$fell(flash_pins.we_n) ##0 !flash_pins.we_n [*5] ##1 flash_pins.we_n;
	endsequence

	sequence seq_re_pulse;
		(flash_pins.flash_read_strobe_n != 2'h3) [*8] ##1 (flash_pins.flash_read_strobe_n == 2'h3);
	endsequence

	AST_ONE_CE: assert property ($onehot0(~flash_pins.ce_n))
		else $error("more than one chip select active");
	AST_CLE_ALE: assert property (!flash_pins.we_n |-> !(flash_pins.cle && flash_pins.ale))
		else $error("command and address strobes together");
	AST_WE_LEN: assert property ($fell(flash_pins.we_n) |-> seq_we_pulse)
		else $error("write strobe not five cycles low");
	AST_RE_LEN: assert property ($changed(flash_pins.flash_read_strobe_n) &&
			flash_pins.flash_read_strobe_n != 2'h3 |-> seq_re_pulse)
		else $error("read strobe not eight cycles low");
	AST_BUS_DRIVEN: assert property (!flash_pins.we_n |->
			!flash_pins.dq_oe_n && $stable(flash_pins.dq_out))
		else $error("bus not held during write strobe");
	AST_CMD_LATCH: assert property ($rose(flash_pins.we_n) && $past(flash_pins.cle)
			|-> $past(op_r.op, 2) == NFPS_OP_CMD)
		else $error("command strobe without command");
	AST_ADDR_LATCH: assert property ($rose(flash_pins.we_n) && $past(flash_pins.ale)
			|-> $past(op_r.op, 2) == NFPS_OP_ADDR)
		else $error("address strobe without address");
	AST_BUSY_HOLD: assert property (state_r == ENG_SETUP && $past(state_r == ENG_IDLE)
			|-> (op_r.chip[2] ? $past(rb_s[1]) : $past(rb_s[0])))
		else $error("operation started while flash busy");
	AST_WP_WAIT: assert property ($fell(flash_write_protect_out_n) |-> flash_pins.dq_oe_n
			&& flash_pins.we_n && !rd_valid)
		else $error("flash protect asserted during transfer");
	AST_CFG_REFUSE: assert property (req_valid && req_ready && cfg_wr_blk
			|-> ##1 req_refused ##1 !$past(host_go, 2))
		else $error("protected config write not refused");
	AST_MODE_GATE: assert property (state_r == ENG_SETUP && $past(state_r == ENG_IDLE)
			&& init_done_r && !normal_r |-> op_r.cfg_area)
		else $error("host access outside normal mode");
	AST_CHIP_ACTIVE_INDICATOR_N: assert property ($rose(init_done_r) |=> !chip_active_oe_n)
		else $error("chip active indicator not driven");
endmodule

/* File: core/nfps_consts.svh */
`ifndef NFPS_CONSTS_SVH
`define NFPS_CONSTS_SVH

`define NFPS_CLK_MHZ       100
`define NFPS_STROBE_NS     50
`define NFPS_STROBE_CYC    ((`NFPS_STROBE_NS * `NFPS_CLK_MHZ + 999) / 1000)
`define NFPS_SETUP_CYC     2
`define NFPS_SYNC_LAT      2
`define NFPS_WB_NS         100
`define NFPS_WB_CYC        ((`NFPS_WB_NS * `NFPS_CLK_MHZ + 999) / 1000)
`define NFPS_RST_HOLD_MS   10
`define NFPS_RST_HOLD_CYC  (`NFPS_RST_HOLD_MS * 1000 * 1000 * `NFPS_CLK_MHZ / 1000)
`define NFPS_CMD_READ      8'h00
`define NFPS_CMD_CONFIRM   8'h30
`define NFPS_CFG_ADDR      8'h00
`define NFPS_CFG_SIG       8'hA5
`define NFPS_BOOT_STEPS    4'hA
`define NFPS_DEF_VENDOR    16'h1234
`define NFPS_DEF_PRODUCT   16'h5678
`define NFPS_DEF_WP_CAP    1'h1
`define NFPS_FLAG_WP_BIT   0
`define NFPS_DATA_W        8
`define NFPS_FIFO_DEPTH    32

`endif

/* File: core/nfps_pkg.sv */
package nfps_pkg;

	typedef enum logic [1:0] {
		NFPS_OP_CMD,
		NFPS_OP_ADDR,
		NFPS_OP_WRITE,
		NFPS_OP_READ
	} nfps_op_type;

	typedef struct packed {
		nfps_op_type op;
		logic [2:0]  chip;
		logic        cfg_area;
		logic [7:0]  data;
	} nfps_req_type;

	typedef enum logic [1:0] {
		NFPS_SPD_LOW,
		NFPS_SPD_FULL,
		NFPS_SPD_HIGH
	} nfps_speed_type;

	typedef struct packed {
		logic [15:0] vendor;
		logic [15:0] product;
		logic        wp_capable;
	} nfps_cfg_type;

	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       we_n;
		logic [1:0] flash_read_strobe_n;
		logic [7:0] ce_n;
		logic [7:0] dq_out;
		logic       dq_oe_n;
	} nfps_pins_type;

endpackage

/* File: core/nfps_sync.sv */
module nfps_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_r;

	// meta_r is read by dout only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_r <= '1;
			dout   <= '1;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule

/* File: core/nfps_fifo.sv */
module nfps_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wr_r;
	logic [AW:0]  rd_r;
	wire          push = in_valid & in_ready;
	wire          pop  = out_valid & out_ready;

	assign in_ready  = (wr_r[AW-1:0] != rd_r[AW-1:0]) | (wr_r[AW] == rd_r[AW]);
	assign out_valid = wr_r != rd_r;
	assign out_data  = mem[rd_r[AW-1:0]];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_r + (AW+1)'(push);
			rd_r <= rd_r + (AW+1)'(pop);
		end
	end
endmodule

/* File: dv/nfps_flash_model.sv */
module nfps_flash_model import nfps_pkg::*; (
	input  wire logic          clk_sys,
	input  wire nfps_pins_type pins,
	input  wire logic    [7:0] bus,
	input  wire logic    [7:0] sig,
	output logic         [7:0] dq_drv,
	output logic         [1:0] ready_busy_n,
	output logic         [7:0] last_cmd
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [16];
	logic [3:0] col      = 4'h0;
	logic [7:0] last_dq  = 8'h00;
	logic [7:0] out_byte = 8'h00;
	int         cyc      = 0;
	int         busy_end = 0;
	logic       busy_hi  = 1'b0;
	wire        sel      = ~&pins.ce_n;
	wire        rd_all   = &pins.flash_read_strobe_n;

	initial begin
		ready_busy_n = 2'h3;
		last_cmd = 8'h00;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 8'h40 + 8'(i);
		end
	end

	// no pull on the data lines, so a released bus flips every cycle
	assign dq_drv = (sel && !rd_all) ? out_byte : ~last_dq;

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		last_dq <= bus;
		ready_busy_n <= {~(cyc < busy_end && busy_hi), ~(cyc < busy_end && !busy_hi)};
	end

	always @(negedge rd_all) begin
		if (sel) begin
			out_byte <= (col == 4'h0) ? sig : mem[col];
			col <= col + 4'h1;
		end
	end

	always @(posedge pins.we_n) begin
		if (sel && pins.cle) begin
			last_cmd <= bus;
			if (bus == 8'h30) begin
				busy_end <= cyc + 30;
				busy_hi <= (pins.ce_n[3:0] == 4'hF);
			end
		end else if (sel && pins.ale) begin
			col <= bus[3:0];
		end else if (sel) begin
			mem[col] <= bus;
			col <= col + 4'h1;
		end
	end
endmodule

/* File: dv/tb_nand_flash_port_and_mode_select.sv */
`include "nfps_consts.svh"

module tb_nand_flash_port_and_mode_select import nfps_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic           clk_sys    = 1'b0;
	logic           rst        = 1'b1;
	logic           reset_in_n = 1'b1;
	nfps_req_type   req        = '0;
	logic           req_valid  = 1'b0;
	logic           rd_ready   = 1'b0;
	logic           req_ready, req_refused, rd_valid, took, refd, act;
	logic     [7:0] rd_data, flash_dq_in, dq_drv, last_cmd, we_ce, e;
	nfps_pins_type  flash_pins;
	logic     [1:0] flash_ready_busy_n;
	logic           write_protect_switch_n = 1'b1;
	logic           flash_write_protect_out_n, flash_write_protect_oe_n;
	logic           data_activity_indicator_n, data_activity_oe_n;
	logic           chip_active_indicator_n, chip_active_oe_n;
	nfps_speed_type speed_req = NFPS_SPD_LOW;
	nfps_speed_type speed_grant;
	logic           normal_mode, init_done, media_write_protected;
	nfps_cfg_type   cfg;
	logic     [7:0] sig         = 8'hA5;
	int             failures    = 0;
	int             check_count = 0;
	int             wait_lim    = 400;
	time            we_fall     = 0;

	nfps_top #(.RST_HOLD_CYC(20)) uut (
		.clk_sys, .rst, .reset_in_n, .req, .req_valid, .req_ready, .req_refused,
		.rd_data, .rd_valid, .rd_ready, .flash_pins, .flash_dq_in, .flash_ready_busy_n,
		.write_protect_switch_n, .flash_write_protect_out_n, .flash_write_protect_oe_n,
		.data_activity_indicator_n, .data_activity_oe_n, .chip_active_indicator_n,
		.chip_active_oe_n, .speed_req, .speed_grant, .normal_mode, .init_done,
		.media_write_protected, .cfg
	);
	nfps_flash_model fm (.clk_sys, .pins(flash_pins), .bus(flash_dq_in), .sig, .dq_drv,
		.ready_busy_n(flash_ready_busy_n), .last_cmd);

	assign flash_dq_in = (flash_pins.dq_oe_n === 1'b0) ? flash_pins.dq_out : dq_drv;

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic op(input nfps_op_type o, input logic [2:0] c, input logic a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk_sys);
		req = '{o, c, a, d};
		req_valid = 1'b1;
		#1;
		while (req_ready !== 1'b1 && n < wait_lim) begin
			@(negedge clk_sys);
			#1;
			n++;
		end
		took = (req_ready === 1'b1);
		if (took) begin
			@(posedge clk_sys);
		end
		@(negedge clk_sys);
		req_valid = 1'b0;
		refd = req_refused;
		if (wait_lim > 100) chk(48'(took), 48'h1, "request taken");
		if (took && !refd) begin
			repeat (4) @(negedge clk_sys);
			act = data_activity_oe_n;
			repeat (8) @(negedge clk_sys);
			chk(48'(act), 48'h0, "activity led driven");
		end
	endtask

	task automatic pop(input logic [7:0] exp);
		int n;
		n = 0;
		while (rd_valid !== 1'b1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		chk(48'(rd_data), 48'(exp), "read byte");
		rd_ready = 1'b1;
		@(negedge clk_sys);
		rd_ready = 1'b0;
		// one idle edge so back-to-back pops never rewrite rd_ready in one step
		@(negedge clk_sys);
	endtask

	task automatic wait_init();
		int n;
		n = 0;
		while (init_done !== 1'b1 && n < 2000) begin
			@(negedge clk_sys);
			n++;
		end
		chk(48'(init_done), 48'h1, "startup finished");
	endtask

	always @(negedge flash_pins.we_n) begin
		we_fall = $time;
	end

	always @(posedge flash_pins.we_n) begin
		we_ce = flash_pins.ce_n;
		if (!rst) chk(48'(flash_pins.cle & flash_pins.ale), 48'h0, "cle with ale");
		if (!rst) chk(48'($time - we_fall), 48'(`NFPS_STROBE_NS), "strobe length");
	end

	always @(posedge clk_sys) begin
		if (!rst && init_done === 1'b1) begin
			chk(48'($countones(~flash_pins.ce_n) <= 1), 48'h1, "chip selects");
			if (normal_mode && req_valid && req_ready && !req.cfg_area)
				chk(48'(flash_ready_busy_n[req.chip[2]]), 48'h1, "taken while busy");
		end
	end

	initial begin
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		chk(48'(chip_active_oe_n), 48'h1, "led before init");
		wait_init();
		chk(48'(normal_mode), 48'h1, "normal mode");
		chk(48'(cfg), 48'({16'h4142, 16'h4344, 1'b1}), "stored config");
		chk(48'({chip_active_oe_n, chip_active_indicator_n, data_activity_indicator_n}),
			48'h0, "led after init");
		chk(48'(speed_grant != NFPS_SPD_LOW), 48'h1, "no low speed");
		speed_req = NFPS_SPD_HIGH;
		repeat (4) @(negedge clk_sys);
		chk(48'(speed_grant), 48'(NFPS_SPD_HIGH), "high speed");
		speed_req = NFPS_SPD_FULL;
		repeat (4) @(negedge clk_sys);
		chk(48'(speed_grant), 48'(NFPS_SPD_FULL), "full speed");
		$display("test startup done");
		op(NFPS_OP_CMD, 3'h5, 1'b0, 8'h80);
		chk(48'(we_ce), 48'hDF, "chip select five");
		chk(48'(last_cmd), 48'h80, "command latched");
		op(NFPS_OP_ADDR, 3'h5, 1'b0, 8'h07);
		chk(48'(fm.col), 48'h7, "address latched");
		op(NFPS_OP_WRITE, 3'h5, 1'b0, 8'hC3);
		chk(48'(fm.mem[7]), 48'hC3, "data latched");
		op(NFPS_OP_ADDR, 3'h5, 1'b0, 8'h07);
		op(NFPS_OP_READ, 3'h5, 1'b0, 8'h00);
		pop(8'hC3);
		op(NFPS_OP_CMD, 3'h5, 1'b0, 8'h30);
		op(NFPS_OP_READ, 3'h5, 1'b0, 8'h00);
		pop(8'h48);
		$display("test bus cycles done");
		op(NFPS_OP_ADDR, 3'h2, 1'b0, 8'h01);
		for (int i = 0; i < `NFPS_FIFO_DEPTH; i++) op(NFPS_OP_READ, 3'h2, 1'b0, 8'h00);
		wait_lim = 40;
		op(NFPS_OP_READ, 3'h2, 1'b0, 8'h00);
		chk(48'(took), 48'h0, "read held off when full");
		wait_lim = 400;
		for (int i = 1; i <= `NFPS_FIFO_DEPTH; i++) begin
			e = (i % 16 == 0) ? 8'hA5 : (i % 16 == 7) ? 8'hC3 : 8'h40 + 8'(i % 16);
			pop(e);
		end
		repeat (4) @(negedge clk_sys);
		chk(48'(data_activity_oe_n), 48'h1, "activity led released");
		$display("test buffer done");
		fork
			op(NFPS_OP_WRITE, 3'h5, 1'b0, 8'h11);
			begin
				repeat (2) @(negedge clk_sys);
				write_protect_switch_n = 1'b0;
				repeat (5) @(negedge clk_sys);
				chk(48'(flash_write_protect_out_n), 48'h1, "protect held off");
			end
		join
		repeat (6) @(negedge clk_sys);
		chk(48'({flash_write_protect_out_n, flash_write_protect_oe_n, media_write_protected}),
			48'h1, "protect on");
		op(NFPS_OP_WRITE, 3'h0, 1'b1, 8'h22);
		chk(48'(refd), 48'h1, "config write refused");
		write_protect_switch_n = 1'b1;
		$display("test write protect done");
		sig = 8'h5A;
		reset_in_n = 1'b0;
		repeat (40) @(negedge clk_sys);
		chk(48'(init_done), 48'h0, "pin reset");
		reset_in_n = 1'b1;
		wait_init();
		chk(48'(normal_mode), 48'h0, "manufacturing mode");
		chk(48'(cfg), 48'({`NFPS_DEF_VENDOR, `NFPS_DEF_PRODUCT, `NFPS_DEF_WP_CAP}),
			"defaults");
		op(NFPS_OP_READ, 3'h0, 1'b0, 8'h00);
		chk(48'(refd), 48'h1, "host access refused");
		op(NFPS_OP_CMD, 3'h1, 1'b1, 8'h90);
		chk(48'({refd, last_cmd}), 48'h090, "config programming");
		$display("test manufacturing done");
		close_out();
	end

	// whole run is a little over a thousand cycles
	initial begin
		#200us;
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		close_out();
	end
endmodule
